// file: logic/smon_map.svh
// Purpose: Named constants for the stand-by ring monitor.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Times are in milliseconds, the clock rate in kilohertz.
`ifndef SMON_MAP_SVH
`define SMON_MAP_SVH

`define SMON_CLK_KHZ 64'd250000
`define SMON_TOKEN_MS 64'd2600
`define SMON_POLL_MS 64'd15000

`define SMON_EV_N 5
`define SMON_EV_GOOD 0
`define SMON_EV_AMP 1
`define SMON_EV_PURGE 2
`define SMON_EV_CLAIM 3
`define SMON_EV_BEACON 4

`define SMON_HW_N 3
`define SMON_HW_WIRE 0
`define SMON_HW_FREQ 1
`define SMON_HW_LOSS 2

`define SMON_PRIO_ZERO 3'h0
`define SMON_CNT_ONE 32'h1
`define SMON_CNT_ZERO 32'h0

`endif

// file: logic/smon_pkg.sv
// Purpose: Types shared by the stand-by ring monitor modules.
// Assumes: Nothing beyond the map header.
// Notes: State and action codes are one-hot.
package smon_pkg;

  typedef logic [2:0] smon_prio_t;

  typedef enum logic [2:0]
  {
    SMON_ST_IDLE = 3'h1,
    SMON_ST_ACTIVE = 3'h2,
    SMON_ST_EXIT = 3'h4
  } smon_state_t;

  typedef enum logic [3:0]
  {
    SMON_ACT_CONTEND_TX = 4'h1,
    SMON_ACT_CONTEND = 4'h2,
    SMON_ACT_BEACON_RPT = 4'h4,
    SMON_ACT_DEINSERT = 4'h8
  } smon_act_t;

endpackage

// file: logic/smon_timer.sv
// Purpose: Supervision timer with restart and an expiry flag that stays high while run holds it at the end.
// Assumes: Runs on the system clock, reset already synchronised.
// Notes: Holds at LIMIT - 1 once expired until restarted or run drops.
`include "smon_map.svh"

module smon_timer #(
  parameter logic [31:0] LIMIT = 32'h10
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  output logic expire
);
  import smon_pkg::*;

  logic [31:0] count_q;
  logic [31:0] count_d;
  wire at_end = (count_q == LIMIT - `SMON_CNT_ONE);

  assign count_d = (restart || !run) ? `SMON_CNT_ZERO :
                   at_end ? count_q : count_q + `SMON_CNT_ONE;
  // Expiry is combinational so the exception is taken on the very edge
  assign expire = run && !restart && at_end;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= `SMON_CNT_ZERO;
    else
      count_q <= count_d;
  end
endmodule

// file: logic/smon_link.sv
// Purpose: Ring-side decode of received tokens and frames on the
//   recovered receive clock; each event leaves as a toggle.
// Assumes: Strobes are one receive-clock cycle wide and arrive in
//   ring order; the recovered clock may stop between frames.
// Notes: Toggles survive a stopped clock, so no event is half sent.
`include "smon_map.svh"

module smon_link (
  input wire logic rx_clk,
  input wire logic rst_n,
  input wire logic token_stb,
  input wire logic frame_stb,
  input wire smon_pkg::smon_prio_t prio,
  input wire logic amp_stb,
  input wire logic purge_stb,
  input wire logic claim_stb,
  input wire logic beacon_stb,
  output logic [`SMON_EV_N-1:0] ev_tgl
);
  import smon_pkg::*;

  logic rst_s1_q;
  logic rst_s2_q;
  logic armed_q;
  logic armed_d;
  logic [`SMON_EV_N-1:0] ev_tgl_q;
  logic [`SMON_EV_N-1:0] ev_hit;

  wire prio_zero = (prio == `SMON_PRIO_ZERO);
  // Priority token waits for the next frame to prove it good
  wire good_now = (token_stb && prio_zero) ||
                  (frame_stb && armed_q && !prio_zero);

  assign armed_d = token_stb ? !prio_zero :
                   frame_stb ? 1'b0 : armed_q;
  assign ev_hit[`SMON_EV_GOOD] = good_now;
  assign ev_hit[`SMON_EV_AMP] = amp_stb;
  assign ev_hit[`SMON_EV_PURGE] = purge_stb;
  assign ev_hit[`SMON_EV_CLAIM] = claim_stb;
  assign ev_hit[`SMON_EV_BEACON] = beacon_stb;
  assign ev_tgl = ev_tgl_q;

  always_ff @(posedge rx_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge rx_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
      ev_tgl_q <= '0;
    end
    else if (rst_s2_q)
    begin
      armed_q <= armed_d;
      ev_tgl_q <= ev_tgl_q ^ ev_hit;
    end
  end
endmodule

// file: logic/smon_top.sv
// Purpose: Stand-by monitor supervision for a token-passing ring adapter.
// Assumes: Process-state inputs come from adapter logic on SYS_CLK;
//   frame strobes come on the recovered clock RX_CLK; hardware error
//   levels come from pins.
// Notes: Exception actions leave as one-cycle pulses one cycle after
//   supervision has already dropped.
`include "smon_map.svh"

module smon_top #(
  parameter logic [31:0] TOKEN_CYCLES =
    32'(`SMON_TOKEN_MS * `SMON_CLK_KHZ),
  parameter logic [31:0] POLL_CYCLES =
    32'(`SMON_POLL_MS * `SMON_CLK_KHZ)
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic RX_CLK,
  input wire logic RX_TOKEN_STB,
  input wire logic RX_FRAME_STB,
  input wire smon_pkg::smon_prio_t RX_PRIO,
  input wire logic RX_AMP_STB,
  input wire logic RX_PURGE_STB,
  input wire logic RX_CLAIM_STB,
  input wire logic RX_BEACON_STB,
  input wire logic WIRE_FAULT_PIN,
  input wire logic FREQ_ERR_PIN,
  input wire logic SIG_LOSS_PIN,
  input wire logic INSERT_DONE,
  input wire logic WON_PHASE1,
  input wire logic CONT_REPEAT,
  input wire logic AM_ACTIVE,
  input wire logic AM_TAKEOVER,
  input wire logic IN_INSERT,
  input wire logic IN_BEACON,
  input wire logic IN_CONTEND,
  input wire logic AM_ERROR,
  input wire logic LOBE_FAULT_CLR,
  output logic SBY_ACTIVE,
  output logic TX_CLK_RECOVERED,
  output logic CIRC_FIX_OFF,
  output logic GO_CONTEND_TX,
  output logic GO_CONTEND,
  output logic GO_BEACON_RPT,
  output logic GO_DEINSERT,
  output logic LOBE_FAULT,
  output logic HW_WIRE_FAULT,
  output logic HW_FREQ_ERR,
  output logic HW_SIG_LOSS
);
  import smon_pkg::*;

  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n_i;

  // Crossings
  logic [`SMON_EV_N-1:0] ev_tgl;
  logic [`SMON_EV_N-1:0] ev_s1_q;
  logic [`SMON_EV_N-1:0] ev_s2_q;
  logic [`SMON_EV_N-1:0] ev_s3_q;
  logic [`SMON_EV_N-1:0] ev_pulse;
  logic [`SMON_HW_N-1:0] hw_pin;
  logic [`SMON_HW_N-1:0] hw_s1_q;
  logic [`SMON_HW_N-1:0] hw_s2_q;

  // Supervision state
  smon_state_t state_q;
  smon_state_t state_d;
  smon_act_t act_q;
  smon_act_t act_d;
  logic sby_q;
  logic sby_d;
  logic go_tx_q;
  logic go_ct_q;
  logic go_bcn_q;
  logic go_dei_q;
  logic lobe_q;
  logic lobe_d;
  logic tok_expire;
  logic poll_expire;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n_i = rst_s2_q;

  smon_link u_link (
    .rx_clk(RX_CLK),
    .rst_n(RST_N),
    .token_stb(RX_TOKEN_STB),
    .frame_stb(RX_FRAME_STB),
    .prio(RX_PRIO),
    .amp_stb(RX_AMP_STB),
    .purge_stb(RX_PURGE_STB),
    .claim_stb(RX_CLAIM_STB),
    .beacon_stb(RX_BEACON_STB),
    .ev_tgl(ev_tgl)
  );

  // Toggle crossing: the third stage only feeds the edge compare
  genvar gi;
  generate
    for (gi = 0; gi < `SMON_EV_N; gi++)
    begin : g_ev
      always_ff @(posedge SYS_CLK or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          ev_s1_q[gi] <= 1'b0;
          ev_s2_q[gi] <= 1'b0;
          ev_s3_q[gi] <= 1'b0;
        end
        else
        begin
          ev_s1_q[gi] <= ev_tgl[gi];
          ev_s2_q[gi] <= ev_s1_q[gi];
          ev_s3_q[gi] <= ev_s2_q[gi];
        end
      end
      assign ev_pulse[gi] = ev_s2_q[gi] ^ ev_s3_q[gi];
    end
  endgenerate

  assign hw_pin[`SMON_HW_WIRE] = WIRE_FAULT_PIN;
  assign hw_pin[`SMON_HW_FREQ] = FREQ_ERR_PIN;
  assign hw_pin[`SMON_HW_LOSS] = SIG_LOSS_PIN;

  generate
    for (gi = 0; gi < `SMON_HW_N; gi++)
    begin : g_hw
      always_ff @(posedge SYS_CLK or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          hw_s1_q[gi] <= 1'b0;
          hw_s2_q[gi] <= 1'b0;
        end
        else
        begin
          hw_s1_q[gi] <= hw_pin[gi];
          hw_s2_q[gi] <= hw_s1_q[gi];
        end
      end
    end
  endgenerate

  // Three separate hardware error conditions
  wire hw_wire = hw_s2_q[`SMON_HW_WIRE];
  wire hw_freq = hw_s2_q[`SMON_HW_FREQ];
  wire hw_loss = hw_s2_q[`SMON_HW_LOSS];

  wire ev_good = ev_pulse[`SMON_EV_GOOD];
  wire ev_amp = ev_pulse[`SMON_EV_AMP];
  wire ev_purge = ev_pulse[`SMON_EV_PURGE];
  wire ev_claim = ev_pulse[`SMON_EV_CLAIM];
  wire ev_beacon = ev_pulse[`SMON_EV_BEACON];

  wire start_ins = INSERT_DONE && !WON_PHASE1;
  wire start_purge = ev_purge && CONT_REPEAT;
  wire start_am = AM_TAKEOVER && AM_ACTIVE && !IN_INSERT;
  wire start_any = start_ins || start_purge || start_am;
  // Leaving a process and starting here share a cycle, so a start wins
  wire busy = IN_INSERT || IN_BEACON || IN_CONTEND;

  wire is_idle = (state_q == SMON_ST_IDLE);
  wire is_active = (state_q == SMON_ST_ACTIVE);
  wire is_exit = (state_q == SMON_ST_EXIT);
  wire entering = is_idle && start_any;

  smon_timer #(
    .LIMIT(TOKEN_CYCLES)
  )
  u_tok (
    .clk(SYS_CLK),
    .rst_n(rst_n_i),
    .run(is_active),
    .restart(entering || ev_good),
    .expire(tok_expire)
  );

  smon_timer #(
    .LIMIT(POLL_CYCLES)
  )
  u_poll (
    .clk(SYS_CLK),
    .rst_n(rst_n_i),
    .run(is_active),
    .restart(entering || ev_amp),
    .expire(poll_expire)
  );

  // Wire fault first: staying on a broken lobe would disturb the ring
  wire exc_dei = hw_wire;
  wire exc_tx = hw_loss || hw_freq || AM_ERROR || tok_expire ||
                poll_expire;
  wire exc_bcn = ev_beacon;
  wire exc_ct = ev_claim;
  wire exc_any = exc_dei || exc_tx || exc_bcn || exc_ct;

  assign act_d = exc_dei ? SMON_ACT_DEINSERT :
                 exc_tx ? SMON_ACT_CONTEND_TX :
                 exc_bcn ? SMON_ACT_BEACON_RPT : SMON_ACT_CONTEND;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SMON_ST_IDLE:
      begin
        if (start_any)
          state_d = SMON_ST_ACTIVE;
      end
      SMON_ST_ACTIVE:
      begin
        if (exc_any)
          state_d = SMON_ST_EXIT;
        else if (busy)
          state_d = SMON_ST_IDLE;
      end
      SMON_ST_EXIT:
        state_d = SMON_ST_IDLE;
      default:
        state_d = SMON_ST_IDLE;
    endcase
  end

  // Supervision flag drops on the edge that leaves ACTIVE
  assign sby_d = (state_d == SMON_ST_ACTIVE);
  // Set wins over a software clear in the same cycle
  assign lobe_d = (is_exit && act_q == SMON_ACT_DEINSERT) ||
                  (lobe_q && !LOBE_FAULT_CLR);

  always_ff @(posedge SYS_CLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SMON_ST_IDLE;
      act_q <= SMON_ACT_CONTEND;
      sby_q <= 1'b0;
      lobe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      act_q <= (is_active && exc_any) ? act_d : act_q;
      sby_q <= sby_d;
      lobe_q <= lobe_d;
    end
  end

  // Actions fire only once supervision is already off
  always_ff @(posedge SYS_CLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      go_tx_q <= 1'b0;
      go_ct_q <= 1'b0;
      go_bcn_q <= 1'b0;
      go_dei_q <= 1'b0;
    end
    else
    begin
      go_tx_q <= is_exit && act_q == SMON_ACT_CONTEND_TX;
      go_ct_q <= is_exit && act_q == SMON_ACT_CONTEND;
      go_bcn_q <= is_exit && act_q == SMON_ACT_BEACON_RPT;
      go_dei_q <= is_exit && act_q == SMON_ACT_DEINSERT;
    end
  end

  assign SBY_ACTIVE = sby_q;
  assign TX_CLK_RECOVERED = sby_q;
  assign CIRC_FIX_OFF = sby_q;
  assign GO_CONTEND_TX = go_tx_q;
  assign GO_CONTEND = go_ct_q;
  assign GO_BEACON_RPT = go_bcn_q;
  assign GO_DEINSERT = go_dei_q;
  assign LOBE_FAULT = lobe_q;
  assign HW_WIRE_FAULT = hw_wire;
  assign HW_FREQ_ERR = hw_freq;
  assign HW_SIG_LOSS = hw_loss;
endmodule

// file: test/smon_checker.sv
// Purpose: Port checks for the stand-by ring monitor.
// Assumes: One clock domain, SYS_CLK; bound to smon_top.
// Notes: Timer lengths are judged by the bench, not here.
module smon_checker (
  input logic SYS_CLK,
  input logic RST_N,
  input logic INSERT_DONE,
  input logic WON_PHASE1,
  input logic AM_ERROR,
  input logic IN_INSERT,
  input logic IN_BEACON,
  input logic IN_CONTEND,
  input logic LOBE_FAULT_CLR,
  input logic WIRE_FAULT_PIN,
  input logic FREQ_ERR_PIN,
  input logic SIG_LOSS_PIN,
  input logic SBY_ACTIVE,
  input logic TX_CLK_RECOVERED,
  input logic CIRC_FIX_OFF,
  input logic GO_CONTEND_TX,
  input logic GO_CONTEND,
  input logic GO_BEACON_RPT,
  input logic GO_DEINSERT,
  input logic LOBE_FAULT,
  input logic HW_WIRE_FAULT,
  input logic HW_FREQ_ERR,
  input logic HW_SIG_LOSS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  wire busy = IN_INSERT | IN_BEACON | IN_CONTEND;
  // Wire fault outranks every other exception
  wire exc = SBY_ACTIVE & !HW_WIRE_FAULT;
  wire [3:0] go = {GO_DEINSERT, GO_BEACON_RPT, GO_CONTEND, GO_CONTEND_TX};
  a_follow_sby: assert property (
    CIRC_FIX_OFF == SBY_ACTIVE && TX_CLK_RECOVERED == SBY_ACTIVE)
    else $error("clock or fix state wrong");
  a_insert_start: assert property (
    INSERT_DONE && !WON_PHASE1 && !SBY_ACTIVE && !$past(SBY_ACTIVE)
    |=> SBY_ACTIVE) else $error("no start after insertion");
  a_am_error: assert property (
    exc && AM_ERROR |=> !SBY_ACTIVE ##1 GO_CONTEND_TX)
    else $error("monitor error action");
  a_freq_err: assert property (
    exc && HW_FREQ_ERR |=> ##1 GO_CONTEND_TX) else $error("freq action");
  a_loss_err: assert property (
    exc && HW_SIG_LOSS |=> ##1 GO_CONTEND_TX) else $error("loss action");
  a_wire_fault: assert property (
    SBY_ACTIVE && HW_WIRE_FAULT |=> !SBY_ACTIVE ##1 GO_DEINSERT && LOBE_FAULT)
    else $error("wire fault action");
  a_busy_drop: assert property (
    SBY_ACTIVE && busy |=> !SBY_ACTIVE) else $error("busy kept active");
  a_go_after_drop: assert property (
    |go |-> $onehot(go) && !$past(SBY_ACTIVE) && $past(SBY_ACTIVE, 2))
    else $error("action without drop");
  a_hw_sync: assert property (
    {HW_WIRE_FAULT, HW_FREQ_ERR, HW_SIG_LOSS} ==
    $past({WIRE_FAULT_PIN, FREQ_ERR_PIN, SIG_LOSS_PIN}, 2))
    else $error("hardware error flags wrong");
  a_lobe_hold: assert property (
    LOBE_FAULT && !LOBE_FAULT_CLR |=> LOBE_FAULT) else $error("lobe lost");
endmodule

bind smon_top smon_checker smon_checker_i (.SYS_CLK, .RST_N, .INSERT_DONE,
  .WON_PHASE1, .AM_ERROR, .IN_INSERT, .IN_BEACON, .IN_CONTEND,
  .LOBE_FAULT_CLR, .WIRE_FAULT_PIN, .FREQ_ERR_PIN, .SIG_LOSS_PIN,
  .SBY_ACTIVE, .TX_CLK_RECOVERED, .CIRC_FIX_OFF, .GO_CONTEND_TX,
  .GO_CONTEND, .GO_BEACON_RPT, .GO_DEINSERT, .LOBE_FAULT, .HW_WIRE_FAULT,
  .HW_FREQ_ERR, .HW_SIG_LOSS);

// file: test/smon_ring.sv
// Purpose: Ring model sending tokens and frames on a recovered clock.
// Assumes: Strobe bits: token, frame, present, purge, claim, beacon.
// Notes: The clock stands still between frames, as a real ring may.
module smon_ring (
  output logic rx_clk,
  output logic [5:0] stb,
  output smon_pkg::smon_prio_t prio
);
  timeunit 1ns;
  timeprecision 1ps;
  import smon_pkg::*;
  initial
  begin
    rx_clk = 1'b0;
    stb = 6'h00;
    prio = 3'h5;
  end
  task automatic tick(input int n);
    repeat (n)
    begin
      #40 rx_clk = 1'b1;
      #40 rx_clk = 1'b0;
    end
  endtask
  // Priority is inverted once released so a stale value is never read
  task automatic send(input int k, input smon_prio_t p);
    #40 rx_clk = 1'b1;
    #5 stb[k] = 1'b1;
    prio = p;
    #35 rx_clk = 1'b0;
    #40 rx_clk = 1'b1;
    #5 stb = 6'h00;
    prio = ~p;
    #35 rx_clk = 1'b0;
    tick(2);
  endtask
endmodule

// file: test/tb_top.sv
// Purpose: Self-checking bench for the stand-by ring monitor.
// Assumes: Timers shortened to TOK and POL cycles of SYS_CLK.
// Notes: Ring traffic comes from smon_ring on its own stopping clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TOK = 600;
  localparam int POL = 1500;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, INSERT_DONE = 1'b0, WON_PHASE1 = 1'b0;
  logic CONT_REPEAT = 1'b0, AM_ACTIVE = 1'b0, AM_TAKEOVER = 1'b0;
  logic AM_ERROR = 1'b0, LOBE_FAULT_CLR = 1'b0;
  logic [2:0] busy = 3'h0, pin = 3'h0;
  wire rx_clk;
  wire [5:0] stb;
  wire [2:0] prio, hw;
  wire [3:0] go;
  wire SBY_ACTIVE, TX_CLK_RECOVERED, CIRC_FIX_OFF, LOBE_FAULT;
  int cyc = 0, n_errors = 0, tests_run = 0;
  smon_top #(.TOKEN_CYCLES(32'(TOK)), .POLL_CYCLES(32'(POL))) smon_top_i (
    .SYS_CLK, .RST_N, .RX_CLK(rx_clk), .RX_TOKEN_STB(stb[0]),
    .RX_FRAME_STB(stb[1]), .RX_PRIO(prio), .RX_AMP_STB(stb[2]),
    .RX_PURGE_STB(stb[3]), .RX_CLAIM_STB(stb[4]), .RX_BEACON_STB(stb[5]),
    .WIRE_FAULT_PIN(pin[0]), .FREQ_ERR_PIN(pin[1]), .SIG_LOSS_PIN(pin[2]),
    .INSERT_DONE, .WON_PHASE1, .CONT_REPEAT, .AM_ACTIVE, .AM_TAKEOVER,
    .IN_INSERT(busy[0]), .IN_BEACON(busy[1]), .IN_CONTEND(busy[2]),
    .AM_ERROR, .LOBE_FAULT_CLR, .SBY_ACTIVE, .TX_CLK_RECOVERED,
    .CIRC_FIX_OFF, .GO_CONTEND_TX(go[0]), .GO_CONTEND(go[1]),
    .GO_BEACON_RPT(go[2]), .GO_DEINSERT(go[3]), .LOBE_FAULT,
    .HW_WIRE_FAULT(hw[0]), .HW_FREQ_ERR(hw[1]), .HW_SIG_LOSS(hw[2]));
  smon_ring smon_ring_i (.rx_clk, .stb, .prio);
  initial
    forever #2 SYS_CLK = ~SYS_CLK;
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input string s, input logic [3:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic expect_go(input int k, input int lim);
    for (int i = 0; i < lim && go === 4'h0; i++)
      step(1);
    chk("action", 4'h1 << k, go);
    chk("active", 4'h0, SBY_ACTIVE);
    step(1);
  endtask
  task automatic up();
    logic [3:0] on;
    INSERT_DONE = 1'b1;
    step(1);
    INSERT_DONE = 1'b0;
    step(1);
    on = {1'b0, TX_CLK_RECOVERED, CIRC_FIX_OFF, SBY_ACTIVE};
    chk("start", 4'h7, on);
  endtask
  task automatic s_start();
    WON_PHASE1 = 1'b1;
    INSERT_DONE = 1'b1;
    step(1);
    INSERT_DONE = 1'b0;
    WON_PHASE1 = 1'b0;
    step(2);
    chk("won", 4'h0, SBY_ACTIVE);
    up();
    AM_ERROR = 1'b1;
    step(1);
    AM_ERROR = 1'b0;
    expect_go(0, 4);
    AM_ACTIVE = 1'b1;
    AM_TAKEOVER = 1'b1;
    step(1);
    AM_TAKEOVER = 1'b0;
    step(1);
    chk("takeover", 4'h1, SBY_ACTIVE);
    AM_ACTIVE = 1'b0;
    AM_ERROR = 1'b1;
    step(1);
    AM_ERROR = 1'b0;
    expect_go(0, 4);
  endtask
  task automatic s_busy();
    for (int j = 0; j < 3; j++)
    begin
      up();
      busy[j] = 1'b1;
      step(1);
      chk("busy", 4'h0, SBY_ACTIVE);
      step(1);
      chk("silent", 4'h0, go);
      busy[j] = 1'b0;
      step(2);
    end
  endtask
  task automatic s_hw();
    for (int j = 0; j < 3; j++)
    begin
      up();
      pin[j] = 1'b1;
      expect_go(j == 0 ? 3 : 0, 8);
      chk("hw", 4'h1 << j, hw);
      chk("lobe", j == 0, LOBE_FAULT);
      pin[j] = 1'b0;
      LOBE_FAULT_CLR = 1'b1;
      step(1);
      LOBE_FAULT_CLR = 1'b0;
      step(3);
      chk("clear", 4'h0, {LOBE_FAULT, hw});
    end
  endtask
  task automatic s_frames();
    CONT_REPEAT = 1'b1;
    smon_ring_i.send(3, 3'h0);
    step(1);
    chk("purge", 4'h1, SBY_ACTIVE);
    CONT_REPEAT = 1'b0;
    fork
      smon_ring_i.send(5, 3'h0);
      expect_go(2, 200);
    join
    up();
    fork
      smon_ring_i.send(4, 3'h0);
      expect_go(1, 200);
    join
  endtask
  // Present frames keep restarting the poll timer; then only plain tokens come
  task automatic s_poll();
    int t0;
    up();
    t0 = cyc;
    while (cyc - t0 < POL + 200)
    begin
      smon_ring_i.send(0, 3'h2);
      smon_ring_i.send(1, 3'h1);
      smon_ring_i.send(2, 3'h0);
    end
    chk("alive", 4'h1, SBY_ACTIVE);
    t0 = cyc;
    while (cyc - t0 < POL - 200)
      smon_ring_i.send(0, 3'h0);
    chk("poll wait", 4'h1, SBY_ACTIVE);
    expect_go(0, 250);
  endtask
  // Priority token then priority zero frame is not a good token
  task automatic s_token();
    int t0;
    up();
    t0 = cyc;
    while (cyc - t0 < TOK - 200)
    begin
      smon_ring_i.send(0, 3'h3);
      smon_ring_i.send(1, 3'h0);
    end
    chk("token wait", 4'h1, SBY_ACTIVE);
    expect_go(0, 220);
  endtask
  initial
  begin
    // Ring edge inside reset: the link flops get no reset edge otherwise
    fork
      smon_ring_i.tick(1);
    join_none
    step(16);
    RST_N = 1'b1;
    smon_ring_i.tick(4);
    step(3);
    s_start();
    s_busy();
    s_hw();
    s_frames();
    s_poll();
    s_token();
    conclude();
  end
endmodule
